// ---- include/xdm_defs.svh ----
// Constants of the external device monitor: register offsets, fields, reset values,
// diagnostic codes and response timing.
// Assumes a 125 MHz clock and a 32-bit register port addressed in bytes.
`ifndef XDM_DEFS_SVH
`define XDM_DEFS_SVH

// Clock and response timing
`define XDM_CLK_MHZ 125
`define XDM_RESP_TIME_MS 0
`define XDM_RESP_CYC_RAW (`XDM_RESP_TIME_MS * `XDM_CLK_MHZ * 1000)
`define XDM_RESP_CYC ((`XDM_RESP_CYC_RAW < 1) ? 1 : `XDM_RESP_CYC_RAW)
`define XDM_TMR_W 32

// Register offsets (byte addresses)
`define XDM_ADDR_W 8
`define XDM_OFS_CTRL 8'h00
`define XDM_OFS_LIMIT 8'h04
`define XDM_OFS_STATUS 8'h08
`define XDM_OFS_IRQ_STAT 8'h0C
`define XDM_OFS_IRQ_MASK 8'h10

// Control register fields and reset value
`define XDM_CTRL_AUTO_START 0
`define XDM_CTRL_RST 32'h0000_0000

// Status register fields
`define XDM_ST_READY 0
`define XDM_ST_ENABLE 1
`define XDM_ST_ERROR 2
`define XDM_ST_CODE_LO 16

// Interrupt event bits and reset values
`define XDM_IRQ_N 3
`define XDM_EV_ERROR 0
`define XDM_EV_ON 1
`define XDM_EV_OFF 2
`define XDM_IRQ_RST 3'h0

// Diagnostic codes
`define XDM_DC_IDLE 16'h0000
`define XDM_DC_INIT 16'h8001
`define XDM_DC_LOCK 16'h8002
`define XDM_DC_OFF 16'h8010
`define XDM_DC_ON 16'h8000
`define XDM_DC_FB1 16'hC010
`define XDM_DC_FB2 16'hC020
`define XDM_DC_FB3 16'hC030
`define XDM_DC_RST1 16'hC001
`define XDM_DC_RST21 16'hC011
`define XDM_DC_RST22 16'hC021
`define XDM_DC_RST23 16'hC031
`define XDM_DC_WIRE 16'hC002

`endif

// ---- include/xdm_pkg.sv ----
// Types of the external device monitor.
// Assumes nothing beyond a SystemVerilog compiler.
package xdm_pkg;

  // Usual path IDLE-INIT-LOCK-OFF-ON is Gray coded
  typedef enum logic [3:0] {
    XDM_IDLE = 4'h0,
    XDM_INIT = 4'h1,
    XDM_LOCK = 4'h3,
    XDM_OFF = 4'h2,
    XDM_ON = 4'h6,
    XDM_FB1 = 4'h7,
    XDM_FB2 = 4'h5,
    XDM_FB3 = 4'h4,
    XDM_RST1 = 4'hC,
    XDM_RST21 = 4'hD,
    XDM_RST22 = 4'hF,
    XDM_RST23 = 4'hE,
    XDM_WIRE = 4'hA
  } xdm_state_e;

  typedef logic [15:0] xdm_code_t;

endpackage

// ---- include/xdm_tmr_if.sv ----
// Carrier between the monitor core and its response timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface xdm_tmr_if #(
  parameter int W = 32
);
  logic run;
  logic [W-1:0] limit;
  logic expired;

  modport ctl (output run, output limit, input expired);
  modport tmr (input run, input limit, output expired);
endinterface

// ---- logic/xdm_resp_timer.sv ----
// Response timer: counts scans while run is high, flags when the limit is reached.
// Assumes run drops whenever the monitored window ends; the count restarts from zero.
`timescale 1ns/1ns
module xdm_resp_timer
  import xdm_pkg::*;
#(
  parameter int W = 32
)(
  input wire logic clk, // Scan clock
  input wire logic rst, // Asynchronous reset, active high
  xdm_tmr_if.tmr t // Run, limit and expiry
);

  logic [W-1:0] cnt;

  // Count scans in the window; saturate so a long stay never wraps into a false pass
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= '0;
      t.expired <= 1'b0;
    end
    else if (!t.run)
    begin
      cnt <= '0;
      t.expired <= 1'b0;
    end
    else
    begin
      if (!t.expired)
      begin
        cnt <= cnt + 1'b1;
      end
      t.expired <= ((cnt + 1'b1) >= t.limit) || t.expired;
    end
  end

endmodule

// ---- logic/xdm_monitor.sv ----
// External device monitor: drives one actuator enable from a control request and
// checks the actuator's two feedback contacts before and after switching.
// Assumes all pins except rst are synchronous to clk; one clock edge is one controller scan.
`timescale 1ns/1ns
`include "xdm_defs.svh"

// Contract
// - Enable output TRUE switches actuator on
// - Both feedbacks at default before enabling
// - Switched feedback within limit, else error
// - Activate low returns to idle, top priority
// - Enter error on reset, feedback, wiring faults
// - Error holds output off, flags, shows code
// - Feedback error cleared by reset rising
// - Reset-signal error cleared by reset falling
// - Startup inhibit held until reset rises
// - Reset high at init gives C001
// - Reset with first feedback rise gives C011
// - Reset with second feedback rise gives C021
// - Reset with both feedbacks rising gives C031
// - Feedback TRUE means actuator at default
module xdm_monitor
  import xdm_pkg::*;
(
  input wire logic clk, // Scan clock, 125 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic activate, // Block enable
  input wire logic control_request_in, // Upstream request to switch on
  input wire logic feedback_first, // First contact, TRUE at default
  input wire logic feedback_second, // Second contact, TRUE at default
  input wire logic reset_in, // Operator acknowledge
  output logic ready, // Block active
  output logic actuator_enable_out, // Actuator drive
  output logic error_out, // Error state present
  output logic [15:0] diagnostic_code, // Current state code
  output logic irq, // Interrupt, level
  input wire logic [`XDM_ADDR_W-1:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata // Read data, cycle after strobe
);

  xdm_state_e state;
  xdm_state_e next_state;
  logic [31:0] ctrl;
  logic [`XDM_TMR_W-1:0] limit;
  logic [`XDM_IRQ_N-1:0] irq_stat;
  logic [`XDM_IRQ_N-1:0] irq_mask;
  logic [`XDM_IRQ_N-1:0] ev;
  logic prev_reset;
  logic prev_fb1;
  logic prev_fb2;
  logic prev_ctrl;
  logic rst_rise;
  logic fb1_rise;
  logic fb2_rise;
  logic ctrl_rise;
  logic auto_start;
  logic at_default;
  logic switched;
  logic is_err;
  xdm_code_t next_code;

  xdm_tmr_if #(.W(`XDM_TMR_W)) tmr ();

  // Response timer runs only while the actuator is commanded on
  assign tmr.run = (state == XDM_ON);
  assign tmr.limit = limit;

  xdm_resp_timer #(.W(`XDM_TMR_W)) u_tmr (
    .clk(clk),
    .rst(rst),
    .t(tmr)
  );

  // Previous-scan copies for edge detection on the pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_reset <= 1'b0;
      prev_fb1 <= 1'b1; // Contacts rest high, so no false rise follows reset
      prev_fb2 <= 1'b1;
      prev_ctrl <= 1'b0;
    end
    else
    begin
      prev_reset <= reset_in;
      prev_fb1 <= feedback_first;
      prev_fb2 <= feedback_second;
      prev_ctrl <= control_request_in;
    end
  end

  assign rst_rise = reset_in && !prev_reset;
  assign fb1_rise = feedback_first && !prev_fb1;
  assign fb2_rise = feedback_second && !prev_fb2;
  assign ctrl_rise = control_request_in && !prev_ctrl;
  assign auto_start = ctrl[`XDM_CTRL_AUTO_START];

  // A shared contact wired to both inputs simply makes both checks agree
  assign at_default = feedback_first && feedback_second;
  assign switched = !feedback_first && !feedback_second;

  // Next state; deactivation is checked first so it overrides everything
  always_comb
  begin
    next_state = state;
    if (!activate)
    begin
      next_state = XDM_IDLE;
    end
    else
    begin
      case (state)
        XDM_IDLE: next_state = XDM_INIT;
        XDM_INIT:
        begin
          // A reset already high here is stuck or miswired
          if (reset_in)
            next_state = XDM_RST1;
          else if (auto_start)
            next_state = XDM_OFF;
          else
            next_state = XDM_LOCK;
        end
        XDM_LOCK:
        begin
          if (rst_rise && ctrl_rise)
            next_state = XDM_WIRE;
          else if (rst_rise)
            next_state = XDM_OFF;
        end
        XDM_OFF:
        begin
          if (control_request_in && at_default)
            next_state = XDM_ON;
          else if (control_request_in && !feedback_first && !feedback_second)
            next_state = XDM_FB3;
          else if (control_request_in && !feedback_first)
            next_state = XDM_FB1;
          else if (control_request_in)
            next_state = XDM_FB2;
        end
        XDM_ON:
        begin
          if (!control_request_in)
            next_state = XDM_OFF;
          else if (tmr.expired && !switched)
          begin
            // Late or lost switching is judged per contact
            if (feedback_first && feedback_second)
              next_state = XDM_FB3;
            else if (feedback_first)
              next_state = XDM_FB1;
            else
              next_state = XDM_FB2;
          end
        end
        XDM_FB1:
        begin
          if (rst_rise && fb1_rise)
            next_state = XDM_RST21;
          else if (rst_rise)
            next_state = XDM_OFF;
        end
        XDM_FB2:
        begin
          if (rst_rise && fb2_rise)
            next_state = XDM_RST22;
          else if (rst_rise)
            next_state = XDM_OFF;
        end
        XDM_FB3:
        begin
          if (rst_rise && fb1_rise && fb2_rise)
            next_state = XDM_RST23;
          else if (rst_rise)
            next_state = XDM_OFF;
        end
        XDM_RST1: if (!reset_in) next_state = XDM_INIT;
        XDM_RST21: if (!reset_in) next_state = XDM_FB1;
        XDM_RST22: if (!reset_in) next_state = XDM_FB2;
        XDM_RST23: if (!reset_in) next_state = XDM_FB3;
        XDM_WIRE: if (!reset_in) next_state = XDM_LOCK;
        default: next_state = XDM_IDLE;
      endcase
    end
  end

  // Code shown for each state
  always_comb
  begin
    case (next_state)
      XDM_IDLE: next_code = `XDM_DC_IDLE;
      XDM_INIT: next_code = `XDM_DC_INIT;
      XDM_LOCK: next_code = `XDM_DC_LOCK;
      XDM_OFF: next_code = `XDM_DC_OFF;
      XDM_ON: next_code = `XDM_DC_ON;
      XDM_FB1: next_code = `XDM_DC_FB1;
      XDM_FB2: next_code = `XDM_DC_FB2;
      XDM_FB3: next_code = `XDM_DC_FB3;
      XDM_RST1: next_code = `XDM_DC_RST1;
      XDM_RST21: next_code = `XDM_DC_RST21;
      XDM_RST22: next_code = `XDM_DC_RST22;
      XDM_RST23: next_code = `XDM_DC_RST23;
      XDM_WIRE: next_code = `XDM_DC_WIRE;
      default: next_code = `XDM_DC_IDLE;
    endcase
  end

  assign is_err = next_code[15] && next_code[14];

  // State and the ready, enable, error and code outputs move together on one edge per scan
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= XDM_IDLE;
      ready <= 1'b0;
      actuator_enable_out <= 1'b0;
      error_out <= 1'b0;
      diagnostic_code <= `XDM_DC_IDLE;
    end
    else
    begin
      state <= next_state;
      ready <= (next_state != XDM_IDLE);
      actuator_enable_out <= (next_state == XDM_ON);
      error_out <= is_err;
      diagnostic_code <= next_code;
    end
  end

  // Events: error entry, enable rise, enable fall
  assign ev[`XDM_EV_ERROR] = is_err && !error_out;
  assign ev[`XDM_EV_ON] = (next_state == XDM_ON) && !actuator_enable_out;
  assign ev[`XDM_EV_OFF] = (next_state != XDM_ON) && actuator_enable_out;

  // Configuration registers; limit never loads zero so the window is at least one scan
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= `XDM_CTRL_RST;
      limit <= `XDM_TMR_W'(`XDM_RESP_CYC);
      irq_mask <= `XDM_IRQ_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `XDM_OFS_CTRL: ctrl <= {31'h0000_0000, reg_wdata[`XDM_CTRL_AUTO_START]};
        `XDM_OFS_LIMIT: limit <= (reg_wdata == 32'h0000_0000) ? 32'h0000_0001 : reg_wdata;
        `XDM_OFS_IRQ_MASK: irq_mask <= reg_wdata[`XDM_IRQ_N-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status; an event in the clearing cycle survives
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_stat <= `XDM_IRQ_RST;
    end
    else if (reg_wr && (reg_addr == `XDM_OFS_IRQ_STAT))
    begin
      irq_stat <= (irq_stat & ~reg_wdata[`XDM_IRQ_N-1:0]) | ev;
    end
    else
    begin
      irq_stat <= irq_stat | ev;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Read port: data valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `XDM_OFS_CTRL: reg_rdata <= ctrl;
        `XDM_OFS_LIMIT: reg_rdata <= limit;
        `XDM_OFS_STATUS: reg_rdata <= {diagnostic_code, 13'h0000, error_out, actuator_enable_out, ready};
        `XDM_OFS_IRQ_STAT: reg_rdata <= {29'h0000_0000, irq_stat};
        `XDM_OFS_IRQ_MASK: reg_rdata <= {29'h0000_0000, irq_mask};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Checks on the monitor's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_reset_rise;
    !reset_in ##1 reset_in;
  endsequence

  sequence s_fb1_err_ack;
    (state == XDM_FB1) && activate ##0 s_reset_rise ##0 (activate && !fb1_rise);
  endsequence

  property p_on_only_in_on;
    actuator_enable_out |-> (state == XDM_ON) && ready && !error_out;
  endproperty
  a_on_only_in_on: assert property (p_on_only_in_on) else $error("enable high outside on state");

  property p_precheck;
    $rose(actuator_enable_out) |-> $past(feedback_first) && $past(feedback_second) && $past(state) == XDM_OFF;
  endproperty
  a_precheck: assert property (p_precheck) else $error("enabled without default feedback");

  property p_late_switch;
    (state == XDM_ON) && activate && control_request_in && tmr.expired && !switched
      |=> error_out && !actuator_enable_out;
  endproperty
  a_late_switch: assert property (p_late_switch) else $error("late feedback not flagged");

  property p_deactivate;
    !activate |=> (state == XDM_IDLE) && !ready && (diagnostic_code == `XDM_DC_IDLE);
  endproperty
  a_deactivate: assert property (p_deactivate) else $error("activate low did not idle");

  property p_error_outputs;
    error_out |-> !actuator_enable_out && ready && diagnostic_code[15:14] == 2'b11;
  endproperty
  a_error_outputs: assert property (p_error_outputs) else $error("error outputs inconsistent");

  property p_fb_ack;
    s_fb1_err_ack |=> (state == XDM_OFF) && !error_out;
  endproperty
  a_fb_ack: assert property (p_fb_ack) else $error("feedback error not cleared");

  property p_fb_hold;
    (state == XDM_FB1) && activate && !rst_rise |=> state == XDM_FB1;
  endproperty
  a_fb_hold: assert property (p_fb_hold) else $error("feedback error left without reset");

  property p_rst_err_clear;
    (state == XDM_RST21) && activate && !reset_in |=> (state == XDM_FB1) && diagnostic_code == `XDM_DC_FB1;
  endproperty
  a_rst_err_clear: assert property (p_rst_err_clear) else $error("reset error not cleared");

  property p_inhibit;
    (state == XDM_LOCK) && activate && !rst_rise |=> (state == XDM_LOCK) && !actuator_enable_out;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("startup inhibit left early");

  property p_code_c001;
    (state == XDM_INIT) && activate && reset_in |=> diagnostic_code == `XDM_DC_RST1 && error_out && ready;
  endproperty
  a_code_c001: assert property (p_code_c001) else $error("stuck reset code wrong");

  property p_code_c011;
    (state == XDM_FB1) && activate && rst_rise && fb1_rise |=> diagnostic_code == `XDM_DC_RST21 && error_out;
  endproperty
  a_code_c011: assert property (p_code_c011) else $error("first feedback reset code wrong");

  property p_code_c021;
    (state == XDM_FB2) && activate && rst_rise && fb2_rise |=> diagnostic_code == `XDM_DC_RST22 && error_out;
  endproperty
  a_code_c021: assert property (p_code_c021) else $error("second feedback reset code wrong");

  property p_code_c031;
    (state == XDM_FB3) && activate && rst_rise && fb1_rise && fb2_rise
      |=> diagnostic_code == `XDM_DC_RST23 && error_out;
  endproperty
  a_code_c031: assert property (p_code_c031) else $error("both feedback reset code wrong");

endmodule

// ---- bench/xdm_actuator.sv ----
// Actuator model with two feedback contacts that follow the drive after a lag.
// Assumes the bench sets the lag in scans and may hold contacts at the switched level.
`timescale 1ns/1ns
module xdm_actuator (
  input wire logic clk, // Scan clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic enable, // Actuator drive from the monitor
  input wire logic [7:0] lag, // Scans from drive change to contact change
  input wire logic [1:0] force_sw, // Contacts held switched, bit 0 is the first
  output logic feedback_first, // First contact, high at default
  output logic feedback_second // Second contact, high at default
);
  logic switched;
  logic [7:0] cnt;

  // Armature follows the drive after lag scans; a drive that drops early cancels the move
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      switched <= 1'b0;
      cnt <= 8'h00;
    end
    else if (enable == switched)
      cnt <= 8'h00;
    else if (cnt + 8'h01 >= lag)
    begin
      switched <= enable;
      cnt <= 8'h00;
    end
    else
      cnt <= cnt + 8'h01;
  end

  // Two separate contacts, each high while resting; forcing models a welded contact
  assign feedback_first = ~(switched | force_sw[0]);
  assign feedback_second = ~(switched | force_sw[1]);
endmodule

// ---- bench/tb.sv ----
// Self-checking bench of the external device monitor with a queue scoreboard.
// Assumes the monitor top, the actuator model and a 125 MHz scan clock.
`timescale 1ns/1ns
`include "xdm_defs.svh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic act = 1'b0;
  logic req = 1'b0;
  logic rin = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pin_chk = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [7:0] lag = 8'h01;
  logic [1:0] force_sw = 2'h0;
  logic [31:0] seed = 32'h0000_001D;
  logic [31:0] exp_q[$];
  logic [15:0] fbc[3] = '{`XDM_DC_FB1, `XDM_DC_FB2, `XDM_DC_FB3};
  logic [15:0] rsc[3] = '{`XDM_DC_RST21, `XDM_DC_RST22, `XDM_DC_RST23};
  int err_count = 0;
  int cmp_count = 0;
  int lim;
  int i;
  wire fb1;
  wire fb2;
  wire ready;
  wire en;
  wire err;
  wire irq;
  wire [15:0] code;
  wire [31:0] reg_rdata;

  always #4 clk = ~clk;

  xdm_monitor i_xdm_monitor (.clk(clk), .rst(rst), .activate(act), .control_request_in(req),
    .feedback_first(fb1), .feedback_second(fb2), .reset_in(rin), .ready(ready),
    .actuator_enable_out(en), .error_out(err), .diagnostic_code(code), .irq(irq),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  xdm_actuator i_xdm_actuator (.clk(clk), .rst(rst), .enable(en), .lag(lag), .force_sw(force_sw),
    .feedback_first(fb1), .feedback_second(fb2));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic compare(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Pins are noted at the sampling edge and judged in the following low phase
  task automatic chk(input logic [15:0] c, input logic [3:0] f);
    @(posedge clk);
    exp_q.push_back({c, 12'h000, f});
    pin_chk <= 1'b1;
    @(posedge clk);
    pin_chk <= 1'b0;
    @(posedge clk);
  endtask

  // Trailing idle edge keeps a strobe from being set twice in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Scoreboard: each settled result takes the oldest note
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk)
  begin
    if (pin_chk)
      compare({code, 12'h000, irq, err, en, ready}, exp_q.pop_front());
    else if (rd_d)
      compare(reg_rdata, exp_q.pop_front());
  end

  // Watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("Watchdog ran out");
    summarize();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Reset values, an unmapped place, limit of zero
    rd(`XDM_OFS_CTRL, 32'h0000_0000);
    rd(`XDM_OFS_LIMIT, 32'h0000_0001);
    rd(`XDM_OFS_STATUS, 32'h0000_0000);
    rd(`XDM_OFS_IRQ_STAT, 32'h0000_0000);
    rd(`XDM_OFS_IRQ_MASK, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    chk(`XDM_DC_IDLE, 4'h0);
    wr(`XDM_OFS_LIMIT, 32'h0000_0000);
    rd(`XDM_OFS_LIMIT, 32'h0000_0001);
    wr(`XDM_OFS_CTRL, 32'h0000_0001);
    rd(`XDM_OFS_CTRL, 32'h0000_0001);
    act <= 1'b1;
    chk(`XDM_DC_INIT, 4'h1);
    chk(`XDM_DC_OFF, 4'h1);
    $display("Test reset and start done");
    // Prompt and late actuators against random limits
    for (i = 0; i < 3; i++)
    begin
      seed = xs(seed);
      lim = 4 + int'(seed % 4);
      lag <= 8'(1 + int'(seed[15:8]) % (lim - 3));
      wr(`XDM_OFS_LIMIT, 32'(lim));
      rd(`XDM_OFS_LIMIT, 32'(lim));
      req <= 1'b1;
      chk(`XDM_DC_ON, 4'h3);
      repeat (lim + 3) @(posedge clk);
      chk(`XDM_DC_ON, 4'h3);
      req <= 1'b0;
      chk(`XDM_DC_OFF, 4'h1);
      repeat (lim) @(posedge clk);
      lag <= 8'h14;
      req <= 1'b1;
      chk(`XDM_DC_ON, 4'h3);
      repeat (lim + 2) @(posedge clk);
      chk(`XDM_DC_FB3, 4'h5);
      req <= 1'b0;
      rin <= 1'b1;
      chk(`XDM_DC_OFF, 4'h1);
      rin <= 1'b0;
      lag <= 8'h01;
      rd(`XDM_OFS_IRQ_STAT, 32'h0000_0007);
      wr(`XDM_OFS_IRQ_STAT, 32'h0000_0007);
      rd(`XDM_OFS_IRQ_STAT, 32'h0000_0000);
    end
    $display("Test response time done");
    // Interrupt masking, then leaving ON by deactivation
    wr(`XDM_OFS_IRQ_MASK, 32'h0000_0007);
    req <= 1'b1;
    chk(`XDM_DC_ON, 4'hB);
    wr(`XDM_OFS_IRQ_MASK, 32'h0000_0000);
    chk(`XDM_DC_ON, 4'h3);
    act <= 1'b0;
    chk(`XDM_DC_IDLE, 4'h0);
    req <= 1'b0;
    rd(`XDM_OFS_IRQ_STAT, 32'h0000_0006);
    wr(`XDM_OFS_IRQ_STAT, 32'h0000_0007);
    $display("Test interrupt done");
    // Welded contacts, acknowledge with simultaneous release
    act <= 1'b1;
    chk(`XDM_DC_INIT, 4'h1);
    chk(`XDM_DC_OFF, 4'h1);
    rd(`XDM_OFS_STATUS, {`XDM_DC_OFF, 16'h0001});
    for (i = 0; i < 3; i++)
    begin
      force_sw <= 2'(i + 1);
      req <= 1'b1;
      chk(fbc[i], 4'h5);
      rin <= 1'b1;
      force_sw <= 2'h0;
      req <= 1'b0;
      chk(rsc[i], 4'h5);
      rin <= 1'b0;
      chk(fbc[i], 4'h5);
      rin <= 1'b1;
      chk(`XDM_DC_OFF, 4'h1);
      rin <= 1'b0;
    end
    $display("Test feedback errors done");
    // Acknowledge held high while starting
    act <= 1'b0;
    chk(`XDM_DC_IDLE, 4'h0);
    rin <= 1'b1;
    act <= 1'b1;
    chk(`XDM_DC_INIT, 4'h1);
    chk(`XDM_DC_RST1, 4'h5);
    rin <= 1'b0;
    chk(`XDM_DC_INIT, 4'h1);
    chk(`XDM_DC_OFF, 4'h1);
    $display("Test stuck acknowledge done");
    // Startup inhibit and a request coupled to the acknowledge
    act <= 1'b0;
    wr(`XDM_OFS_CTRL, 32'h0000_0000);
    act <= 1'b1;
    chk(`XDM_DC_INIT, 4'h1);
    chk(`XDM_DC_LOCK, 4'h1);
    rin <= 1'b1;
    req <= 1'b1;
    chk(`XDM_DC_WIRE, 4'h5);
    rin <= 1'b0;
    req <= 1'b0;
    chk(`XDM_DC_LOCK, 4'h1);
    rin <= 1'b1;
    chk(`XDM_DC_OFF, 4'h1);
    rin <= 1'b0;
    $display("Test startup inhibit done");
    summarize();
  end
endmodule
